// ### shared/rhb_pkg.sv
// Constants for the receive packet status and code readout block
package rhb_pkg;
  // ----------------------------------------------------------------
  // Register map (printed index, byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_PKT_INFO   = 8'h03;          // Receive packet information
  localparam logic [7:0]  IDX_CODE_WORD  = 8'h04;          // Received code word
  localparam logic [7:0]  IDX_FIFO_DATA  = 8'h05;          // Receive FIFO data
  localparam logic [7:0]  IDX_SUMMARY    = 8'h09;          // Summary flags
  localparam logic [11:0] ADDR_PKT_INFO  = {2'h0, IDX_PKT_INFO, 2'h0};
  localparam logic [11:0] ADDR_CODE_WORD = {2'h0, IDX_CODE_WORD, 2'h0};
  localparam logic [11:0] ADDR_FIFO_DATA = {2'h0, IDX_FIFO_DATA, 2'h0};
  localparam logic [11:0] ADDR_SUMMARY   = {2'h0, IDX_SUMMARY, 2'h0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_ABORT = 7;                            // Packet info bits
  localparam int POS_CRC   = 6;
  localparam int POS_OVR   = 5;
  localparam int POS_VM    = 4;
  localparam int POS_EMPTY = 3;
  localparam int POS_GOOD  = 2;
  localparam int POS_CLOSE = 1;
  localparam int POS_OPEN  = 0;
  localparam int POS_LCD   = 7;                            // Code word bits
  localparam int POS_CDN   = 6;
  localparam int POS_SNE   = 0;                            // Summary bits
  localparam int POS_SCHG  = 1;

  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int         FIFO_DEPTH   = 64;
  localparam int         PTR_W        = 6;
  localparam logic [6:0] CNT_FULL     = 7'h40;
  localparam logic [2:0] ABORT_ONES   = 3'h7;              // Ones in a row for abort
  localparam logic [5:0] CODE_RST     = 6'h3F;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
endpackage : rhb_pkg

// ### rtl/rhb_top.sv
// Receive packet status, FIFO readout and code detector register block
`timescale 1ns/100ps

// What this block does
// - Finished, checked packet sets valid-message flag
// - Four packet flags latch, clear on info read
// - Empty flag live, high exactly when FIFO empty
// - Head byte shows opening, closing, good-last flags
// - Code-detected bit live, follows detector
// - Latched code-detected copy, cleared on read
// - Code bits 5:0, bit 0 first received
// - Code field holds last verified code, reset ones
// - FIFO holds 64 bytes; not-empty summary flag
// - Code detect change sets latched summary flag
module rhb_top
  import rhb_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Receive link controller, same clock
  input  wire logic        link_bit,
  input  wire logic        link_bit_valid,
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_open,
  input  wire logic        rx_close,
  input  wire logic        rx_good,
  input  wire logic        rx_pkt_end,
  input  wire logic        rx_crc_ok,
  // Code detector, same clock
  input  wire logic        code_valid,
  input  wire logic        code_verify,
  input  wire logic [5:0]  code_word
);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  logic        aw_have_q;                                  // Write address held
  logic        w_have_q;                                   // Write data held
  logic [11:0] waddr_q;                                    // Held write address
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        rd_info;                                    // Info read this edge
  logic        rd_code;                                    // Code read this edge
  logic        rd_data;                                    // Data read this edge
  logic        rd_sum;                                     // Summary read this edge

  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;
  assign rd_info = ar_hs && (araddr == ADDR_PKT_INFO);
  assign rd_code = ar_hs && (araddr == ADDR_CODE_WORD);
  assign rd_data = ar_hs && (araddr == ADDR_FIFO_DATA);
  assign rd_sum  = ar_hs && (araddr == ADDR_SUMMARY);

  // ----------------------------------------------------------------
  // Receive FIFO storage
  // ----------------------------------------------------------------
  logic [10:0]      mem_q [FIFO_DEPTH];                    // Byte plus three tags
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [6:0]       count_q;                               // Bytes held, 0..64
  logic             fifo_full;
  logic             fifo_empty;
  logic             do_push;
  logic             do_pop;
  logic [10:0]      head;

  assign fifo_full  = (count_q == CNT_FULL);
  assign fifo_empty = (count_q == 7'h00);
  assign do_push    = rx_push && !fifo_full;
  assign do_pop     = rd_data && !fifo_empty;
  assign head       = mem_q[rd_ptr_q];

  // Storage write; a push into a full FIFO is dropped
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= {rx_good, rx_close, rx_open, rx_byte};
    end
  end

  // Pointers and fill count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 6'h01;
      end
      // Count holds when push and pop meet
      if (do_push && !do_pop) begin
        count_q <= count_q + 7'h01;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet flags
  // ----------------------------------------------------------------
  logic [2:0] ones_q;                                      // Ones run, saturating
  logic       abt_q;
  logic       crc_q;
  logic       ovr_q;
  logic       vm_q;
  logic       abt_set;

  assign abt_set = link_bit_valid && link_bit && (ones_q == ABORT_ONES - 3'h1);

  // Ones run counter; stops at seven so a longer run sets abort only once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_q <= 3'h0;
    end else if (link_bit_valid) begin
      if (!link_bit) begin
        ones_q <= 3'h0;
      end else if (ones_q != ABORT_ONES) begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abt_q <= 1'b0;
      crc_q <= 1'b0;
      ovr_q <= 1'b0;
      vm_q  <= 1'b0;
    end else begin
      abt_q <= abt_set || (abt_q && !rd_info);
      crc_q <= (rx_pkt_end && !rx_crc_ok) || (crc_q && !rd_info);
      ovr_q <= (rx_push && fifo_full) || (ovr_q && !rd_info);
      vm_q  <= (rx_pkt_end && rx_crc_ok) || (vm_q && !rd_info);
    end
  end

  // ----------------------------------------------------------------
  // Code detector status
  // ----------------------------------------------------------------
  logic       cdn_q;                                       // Detected now
  logic       lcd_q;                                       // Latched detected
  logic [5:0] code_q;                                      // Last verified code
  logic       chg_q;                                       // Detect change seen

  // Live detect, latched copy, change flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdn_q <= 1'b0;
      lcd_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      cdn_q <= code_valid;
      lcd_q <= cdn_q || (lcd_q && !rd_code);
      chg_q <= (code_valid != cdn_q) || (chg_q && !rd_sum);
    end
  end

  // Only verified codes land; first received bit in bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= CODE_RST;
    end else if (code_verify) begin
      code_q <= code_word;
    end
  end

  // ----------------------------------------------------------------
  // Write channel: all registers read-only, writes answered only
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 12'h000;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else if (bvalid) begin
      // Response out; reopen both channels once taken
      if (bready) begin
        bvalid    <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end else begin
      if (aw_hs) begin
        waddr_q   <= awaddr;
        aw_have_q <= 1'b1;
        awready   <= 1'b0;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wready   <= 1'b0;
      end
      // Respond once both halves are in
      if ((aw_have_q || aw_hs) && (w_have_q || w_hs)) begin
        bvalid <= 1'b1;
        case (aw_hs ? awaddr : waddr_q)
          ADDR_PKT_INFO, ADDR_CODE_WORD,
          ADDR_FIFO_DATA, ADDR_SUMMARY: bresp <= RESP_OKAY;
          default:                      bresp <= RESP_DECERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel with read side effects
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
      case (araddr)
        ADDR_PKT_INFO: begin
          rdata[POS_ABORT] <= abt_q;
          rdata[POS_CRC]   <= crc_q;
          rdata[POS_OVR]   <= ovr_q;
          rdata[POS_VM]    <= vm_q;
          rdata[POS_EMPTY] <= fifo_empty;
          rdata[POS_GOOD]  <= !fifo_empty && head[10];
          rdata[POS_CLOSE] <= !fifo_empty && head[9];
          rdata[POS_OPEN]  <= !fifo_empty && head[8];
        end
        ADDR_CODE_WORD: begin
          rdata[POS_LCD] <= lcd_q;
          rdata[POS_CDN] <= cdn_q;
          rdata[5:0]     <= code_q;
        end
        ADDR_FIFO_DATA: begin
          // Empty FIFO reads as zero and does not move
          rdata[7:0] <= fifo_empty ? 8'h00 : head[7:0];
        end
        ADDR_SUMMARY: begin
          rdata[POS_SNE]  <= !fifo_empty;
          rdata[POS_SCHG] <= chg_q;
        end
        default: begin
          rresp <= RESP_DECERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  crc_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_pkt_end && !rx_crc_ok |=> crc_q)
    else $error("checksum error flag not raised");

  overrun_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_push && fifo_full && !do_pop |=> ovr_q && count_q == CNT_FULL)
    else $error("overrun flag or fill count wrong");

  valid_msg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_pkt_end && rx_crc_ok |=> vm_q)
    else $error("valid message flag not raised");

  info_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_info && !abt_set && !rx_pkt_end && !rx_push |=> !abt_q && !crc_q && !ovr_q && !vm_q)
    else $error("packet flags not cleared by read");

  empty_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_info |=> rdata[POS_EMPTY] == ($past(count_q) == 7'h00))
    else $error("empty flag disagrees with fill count");

  pop_advance_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_data && !fifo_empty && !rx_push |=> count_q == $past(count_q) - 7'h01)
    else $error("data read did not advance FIFO");

  code_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !code_verify |=> $stable(code_q))
    else $error("code field changed without verify");

  code_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
    code_valid != cdn_q |=> chg_q && cdn_q == $past(code_valid))
    else $error("code change flag not raised");

  abort_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    abt_set |=> abt_q && ones_q == ABORT_ONES)
    else $error("abort flag not raised after seven ones");

  latched_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cdn_q |=> lcd_q)
    else $error("latched code detect missed");

endmodule : rhb_top

// ### sim/rhb_far_end.sv
// Far-end terminal model: serial link, byte stream and code detector
`timescale 1ns/100ps
module rhb_far_end (
  // Clock
  input  wire logic  aclk,
  // Serial link
  output logic       link_bit,
  output logic       link_bit_valid,
  // Bytes and packet ends towards the FIFO
  output logic       rx_push,
  output logic [7:0] rx_byte,
  output logic       rx_open,
  output logic       rx_close,
  output logic       rx_good,
  output logic       rx_pkt_end,
  output logic       rx_crc_ok,
  // Code detector
  output logic       code_valid,
  output logic       code_verify,
  output logic [5:0] code_word
);
  // ------------------------------------------------------------
  // Idle levels at time zero
  // ------------------------------------------------------------
  initial begin
    {link_bit, link_bit_valid, rx_push, rx_open, rx_close, rx_good} = '0;
    {rx_pkt_end, rx_crc_ok, code_valid, code_verify, rx_byte, code_word} = '0;
  end
  // Send n bits of one value; idle line then shows the inverse, not a stale copy
  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(posedge aclk);
      {link_bit, link_bit_valid} <= {b, 1'b1};
    end
    @(posedge aclk);
    {link_bit, link_bit_valid} <= {~b, 1'b0};
  endtask : bits
  // One byte with its position tags, a one-cycle push
  task automatic push(input logic [7:0] b, input logic o, input logic c, input logic g);
    @(posedge aclk);
    {rx_push, rx_byte, rx_open, rx_close, rx_good} <= {1'b1, b, o, c, g};
    @(posedge aclk);
    {rx_push, rx_byte} <= {1'b0, ~b};
  endtask : push
  // End of packet with its checksum verdict
  task automatic pend(input logic ok);
    @(posedge aclk);
    {rx_pkt_end, rx_crc_ok} <= {1'b1, ok};
    @(posedge aclk);
    {rx_pkt_end, rx_crc_ok} <= {1'b0, ~ok};
  endtask : pend
  // Detector level, optionally with a freshly verified word
  task automatic code(input logic v, input logic [5:0] w, input logic ver);
    @(posedge aclk);
    {code_valid, code_verify, code_word} <= {v, ver, w};
    @(posedge aclk);
    {code_verify, code_word} <= {1'b0, ~w};
  endtask : code
endmodule : rhb_far_end

// ### sim/rhb_top_test.sv
// Self-checking bench for the receive status and code readout block
`timescale 1ns/100ps
module rhb_top_test import rhb_pkg::*; ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, link_bit, link_bit_valid, rx_push;
  logic        rx_open, rx_close, rx_good, rx_pkt_end, rx_crc_ok, code_valid, code_verify;
  logic [11:0] awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rx_byte;
  logic [5:0]  code_word;
  int          miscompares, total_checks;

  rhb_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link_bit(link_bit), .link_bit_valid(link_bit_valid),
    .rx_push(rx_push), .rx_byte(rx_byte), .rx_open(rx_open), .rx_close(rx_close),
    .rx_good(rx_good), .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok),
    .code_valid(code_valid), .code_verify(code_verify), .code_word(code_word));
  rhb_far_end fe (.aclk(aclk), .link_bit(link_bit), .link_bit_valid(link_bit_valid),
    .rx_push(rx_push), .rx_byte(rx_byte), .rx_open(rx_open), .rx_close(rx_close),
    .rx_good(rx_good), .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok),
    .code_valid(code_valid), .code_verify(code_verify), .code_word(code_word));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // An exhausted wait counts against the run and ends it
  task automatic lim(input int n);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : lim
  // Register read; rready stays up from the start until rvalid is seen
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (arready !== 1'b1 && ++n < 50);
    lim(n);
    arvalid <= 1'b0;
    n = 0;
    do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 50);
    lim(n);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  // Register write; address and data released each at its own handshake
  task automatic wr(input logic [11:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, 32'hFFFF_FFFF};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1)) && ++n < 50);
    lim(n);
    n = 0;
    do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 50);
    lim(n);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_fifo;
    fe.push(8'hA5, 1'b1, 1'b0, 1'b0);
    fe.push(8'h3C, 1'b0, 1'b1, 1'b1);
    rd(ADDR_SUMMARY, 8'h01);
    rd(ADDR_PKT_INFO, 8'h01);
    rd(ADDR_FIFO_DATA, 8'hA5);
    rd(ADDR_PKT_INFO, 8'h06);
    rd(ADDR_FIFO_DATA, 8'h3C);
    rd(ADDR_FIFO_DATA, 8'h00);
    rd(ADDR_PKT_INFO, 8'h08);
    $display("fifo readout test done");
  endtask : t_fifo
  // Fill one past capacity, then drain every byte in order
  task automatic t_fill;
    for (int i = 0; i < 65; i++) fe.push(8'(i), i == 0, i == 63, 1'b0);
    rd(ADDR_PKT_INFO, 8'h21);
    rd(ADDR_PKT_INFO, 8'h01);
    for (int i = 0; i < 64; i++) begin
      if (i == 63) rd(ADDR_PKT_INFO, 8'h02);
      rd(ADDR_FIFO_DATA, 8'(i));
    end
    rd(ADDR_PKT_INFO, 8'h08);
    $display("fifo fill test done");
  endtask : t_fill
  // Packet ends, good and bad, then no abort after six ones, abort after seven
  task automatic t_pkt;
    fe.pend(1'b1);
    rd(ADDR_PKT_INFO, 8'h18);
    fe.pend(1'b0);
    rd(ADDR_PKT_INFO, 8'h48);
    rd(ADDR_PKT_INFO, 8'h08);
    fe.bits(6, 1'b1);
    fe.bits(1, 1'b0);
    rd(ADDR_PKT_INFO, 8'h08);
    fe.bits(7, 1'b1);
    rd(ADDR_PKT_INFO, 8'h88);
    rd(ADDR_PKT_INFO, 8'h08);
    $display("packet flag test done");
  endtask : t_pkt
  // Code detect rise and fall; an unverified word must not land
  task automatic t_code;
    fe.code(1'b1, 6'h01, 1'b1);
    rd(ADDR_CODE_WORD, 8'hC1);
    rd(ADDR_SUMMARY, 8'h02);
    fe.code(1'b0, 6'h3E, 1'b0);
    rd(ADDR_CODE_WORD, 8'h81);
    rd(ADDR_CODE_WORD, 8'h01);
    rd(ADDR_SUMMARY, 8'h02);
    rd(ADDR_SUMMARY, 8'h00);
    wr(ADDR_CODE_WORD, RESP_OKAY);
    wr(12'h100, RESP_DECERR);
    rd(12'h104, 8'h00, RESP_DECERR);
    rd(ADDR_CODE_WORD, 8'h01);
    $display("code and bus test done");
  endtask : t_code
  // Mid-run reset wipes FIFO, sticky flags and the code field
  task automatic t_reset;
    fe.push(8'h5A, 1'b1, 1'b1, 1'b1);
    fe.pend(1'b0);
    fe.code(1'b1, 6'h2A, 1'b1);
    fe.code(1'b0, 6'h15, 1'b0);
    rd(ADDR_CODE_WORD, 8'hAA);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_PKT_INFO, 8'h08);
    rd(ADDR_CODE_WORD, 8'h3F);
    rd(ADDR_SUMMARY, 8'h00);
    $display("mid-run reset test done");
  endtask : t_reset
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wstrb, wdata} = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_PKT_INFO, 8'h08);
    rd(ADDR_CODE_WORD, 8'h3F);
    rd(ADDR_SUMMARY, 8'h00);
    $display("reset values test done");
    t_fifo();
    t_fill();
    t_pkt();
    t_code();
    t_reset();
    tally_and_finish();
  end
endmodule : rhb_top_test
